// ===== gpio_wake_irq_pkg.sv
// Summary of operation
// - a one written to an output-set bit 7..0 forces that output bit high
// - per-port wake monitor enables, one bit per pin, reset to zero
// - wake filter bit 3 filters the channel D wake source
// - wake filter bit 2 filters the serial two wake source on port A pin 2
// - wake filter bit 1 filters the serial one wake source on port B pin 2
// - wake filter bit 0 filters all monitored pin wake sources
// - five-bit selector routes port A, B or C pin to channel C or D
// - channel C selector resets to 0xF, channel D selector to 0x10
// - config bit 8 enables digital filtering before trigger detection, reset zero
// - trigger mode 0 disables, 1 rising edge, 2 falling edge
// - trigger mode 3 fires on both edges
// - mode 4 high level, 5 low level; 6 and 7 reserved, never programmed
// - set and wake registers exist per port, pins in bits 7 down to 0
// - four channel configs, identical layout, reset to zero
// - output data register holds drive values and reads them back
// - a one written to an output-clear bit forces that output bit low
// - triggered channel sets pending flag, cleared only by writing one
package gpio_wake_irq_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int PORT_COUNT = 3;
    localparam int PIN_PER_PORT = 8;
    localparam int PIN_COUNT = PORT_COUNT * PIN_PER_PORT;
    localparam int CHAN_COUNT = 4;
    localparam int SEL_WIDTH = 5;
    localparam int MODE_WIDTH = 3;
    localparam int WAKE_FILT_WIDTH = 4;
    // a pulse must persist this many samples to pass the filter
    localparam int FILTER_SAMPLES = 3;

    // ----------------------------------------------------------------
    // register byte addresses
    // ----------------------------------------------------------------
    localparam logic [31:0] ADDR_PENDING = 32'h4000_a814;
    localparam logic [31:0] ADDR_CFG_A = 32'h4000_a860;
    localparam logic [31:0] ADDR_CFG_B = 32'h4000_a864;
    localparam logic [31:0] ADDR_CFG_C = 32'h4000_a868;
    localparam logic [31:0] ADDR_CFG_D = 32'h4000_a86c;
    localparam logic [31:0] ADDR_OUT_A = 32'h4000_b00c;
    localparam logic [31:0] ADDR_SET_A = 32'h4000_b010;
    localparam logic [31:0] ADDR_CLR_A = 32'h4000_b014;
    localparam logic [31:0] ADDR_OUT_B = 32'h4000_b40c;
    localparam logic [31:0] ADDR_SET_B = 32'h4000_b410;
    localparam logic [31:0] ADDR_CLR_B = 32'h4000_b414;
    localparam logic [31:0] ADDR_OUT_C = 32'h4000_b80c;
    localparam logic [31:0] ADDR_SET_C = 32'h4000_b810;
    localparam logic [31:0] ADDR_CLR_C = 32'h4000_b814;
    localparam logic [31:0] ADDR_WAKE_A = 32'h4000_bc08;
    localparam logic [31:0] ADDR_WAKE_B = 32'h4000_bc0c;
    localparam logic [31:0] ADDR_WAKE_C = 32'h4000_bc10;
    localparam logic [31:0] ADDR_SEL_C = 32'h4000_bc14;
    localparam logic [31:0] ADDR_SEL_D = 32'h4000_bc18;
    localparam logic [31:0] ADDR_WAKE_FILT = 32'h4000_bc1c;

    // ----------------------------------------------------------------
    // fields and reset values
    // ----------------------------------------------------------------
    localparam int CFG_FILT_BIT = 8;
    localparam int CFG_MODE_LSB = 5;
    localparam int WF_PINS_BIT = 0;
    localparam int WF_SERIAL1_BIT = 1;
    localparam int WF_SERIAL2_BIT = 2;
    localparam int WF_CHAN_D_BIT = 3;
    localparam int SERIAL2_PIN = 2;
    localparam int SERIAL1_PIN = 10;
    localparam logic [SEL_WIDTH-1:0] SEL_C_RESET = 5'h0f;
    localparam logic [SEL_WIDTH-1:0] SEL_D_RESET = 5'h10;

    localparam logic [MODE_WIDTH-1:0] MODE_OFF = 3'h0;
    localparam logic [MODE_WIDTH-1:0] MODE_RISE = 3'h1;
    localparam logic [MODE_WIDTH-1:0] MODE_FALL = 3'h2;
    localparam logic [MODE_WIDTH-1:0] MODE_BOTH = 3'h3;
    localparam logic [MODE_WIDTH-1:0] MODE_HIGH = 3'h4;
    localparam logic [MODE_WIDTH-1:0] MODE_LOW = 3'h5;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum {
        KIND_NONE, KIND_CFG, KIND_OUT, KIND_SET, KIND_CLR,
        KIND_WAKE, KIND_SEL, KIND_WFILT, KIND_PEND
    } reg_kind_e;

    typedef struct packed {
        reg_kind_e kind;
        logic [1:0] idx;
    } reg_hit_s;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [31:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_s;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_s;

    typedef struct packed {
        logic [PORT_COUNT-1:0][PIN_PER_PORT-1:0] out_data;
        logic [PORT_COUNT-1:0][PIN_PER_PORT-1:0] wake_en;
        logic [WAKE_FILT_WIDTH-1:0] wake_filt;
        logic [SEL_WIDTH-1:0] sel_c;
        logic [SEL_WIDTH-1:0] sel_d;
        logic [CHAN_COUNT-1:0] cfg_filt;
        logic [CHAN_COUNT-1:0][MODE_WIDTH-1:0] cfg_mode;
        logic [CHAN_COUNT-1:0] pending;
        logic [CHAN_COUNT-1:0] chan_prev;
        logic [PIN_COUNT-1:0] pin_meta;
        logic [PIN_COUNT-1:0] pin_sync;
        logic [PIN_COUNT-1:0] pin_filt;
        logic [PIN_COUNT-1:0][FILTER_SAMPLES-1:0] hist;
        logic sleeping;
        logic [PIN_COUNT-1:0] snap_raw;
        logic [PIN_COUNT-1:0] snap_filt;
        logic wake;
        logic ack;
        logic [31:0] rdata;
    } state_s;

endpackage : gpio_wake_irq_pkg

// ===== gpio_wake_irq_block.sv
// Added by the designer: the Wishbone interface to the registers.
module gpio_wake_irq_block #(
    parameter int IRQ_A_PIN = 8,
    parameter int IRQ_B_PIN = 9
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register bus
    input wire gpio_wake_irq_pkg::wb_req_s wb_req,
    output gpio_wake_irq_pkg::wb_rsp_s wb_rsp,
    // pins
    input wire logic [gpio_wake_irq_pkg::PIN_COUNT-1:0] pin_in,
    output logic [gpio_wake_irq_pkg::PIN_COUNT-1:0] pin_out,
    // sleep control
    input wire logic sleep_req,
    input wire logic serial1_wake_en,
    input wire logic serial2_wake_en,
    input wire logic chan_d_wake_en,
    output logic wake_req,
    // channel pending flags
    output logic [gpio_wake_irq_pkg::CHAN_COUNT-1:0] irq_pending
);
    import gpio_wake_irq_pkg::*;

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (IRQ_A_PIN < 0 || IRQ_A_PIN >= PIN_COUNT || IRQ_B_PIN < 0 || IRQ_B_PIN >= PIN_COUNT)
    begin : g_bad_pin
        $error("fixed channel pins must lie in 0..23");
    end
    if (FILTER_SAMPLES < 2) begin : g_bad_filter
        $error("filter needs at least two samples");
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic reg_hit_s decode(input logic [31:0] adr);
        reg_hit_s h;
        h.kind = KIND_NONE;
        h.idx = 2'h0;
        if (adr == ADDR_PENDING) begin
            h.kind = KIND_PEND;
        end else if (adr == ADDR_CFG_A) begin
            h.kind = KIND_CFG;
        end else if (adr == ADDR_CFG_B) begin
            h.kind = KIND_CFG;
            h.idx = 2'h1;
        end else if (adr == ADDR_CFG_C) begin
            h.kind = KIND_CFG;
            h.idx = 2'h2;
        end else if (adr == ADDR_CFG_D) begin
            h.kind = KIND_CFG;
            h.idx = 2'h3;
        end else if (adr == ADDR_OUT_A) begin
            h.kind = KIND_OUT;
        end else if (adr == ADDR_OUT_B) begin
            h.kind = KIND_OUT;
            h.idx = 2'h1;
        end else if (adr == ADDR_OUT_C) begin
            h.kind = KIND_OUT;
            h.idx = 2'h2;
        end else if (adr == ADDR_SET_A) begin
            h.kind = KIND_SET;
        end else if (adr == ADDR_SET_B) begin
            h.kind = KIND_SET;
            h.idx = 2'h1;
        end else if (adr == ADDR_SET_C) begin
            h.kind = KIND_SET;
            h.idx = 2'h2;
        end else if (adr == ADDR_CLR_A) begin
            h.kind = KIND_CLR;
        end else if (adr == ADDR_CLR_B) begin
            h.kind = KIND_CLR;
            h.idx = 2'h1;
        end else if (adr == ADDR_CLR_C) begin
            h.kind = KIND_CLR;
            h.idx = 2'h2;
        end else if (adr == ADDR_WAKE_A) begin
            h.kind = KIND_WAKE;
        end else if (adr == ADDR_WAKE_B) begin
            h.kind = KIND_WAKE;
            h.idx = 2'h1;
        end else if (adr == ADDR_WAKE_C) begin
            h.kind = KIND_WAKE;
            h.idx = 2'h2;
        end else if (adr == ADDR_SEL_C) begin
            h.kind = KIND_SEL;
        end else if (adr == ADDR_SEL_D) begin
            h.kind = KIND_SEL;
            h.idx = 2'h1;
        end else if (adr == ADDR_WAKE_FILT) begin
            h.kind = KIND_WFILT;
        end
        return h;
    endfunction : decode

    // expands byte selects to a bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        logic [31:0] m;
        m = '0;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{sel[b]}};
        end
        return m;
    endfunction : lane_mask

    // picks raw or filtered level of a pin; reserved codes read low
    function automatic logic pick(input logic [SEL_WIDTH-1:0] idx, input logic use_filt,
                                  input logic [PIN_COUNT-1:0] raw,
                                  input logic [PIN_COUNT-1:0] filt);
        logic v;
        v = 1'b0;
        if (int'(idx) < PIN_COUNT) begin
            v = use_filt ? filt[idx] : raw[idx];
        end
        return v;
    endfunction : pick

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_pipe;
    logic rst_sync_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_pipe[1];

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    state_s st;
    state_s next_st;

    always_comb begin
        reg_hit_s hit;
        logic access;
        logic wr;
        logic [31:0] mask;
        logic [31:0] merged;
        logic [31:0] wbits;
        logic [CHAN_COUNT-1:0][SEL_WIDTH-1:0] chan_sel;
        logic [CHAN_COUNT-1:0] trig;
        logic [CHAN_COUNT-1:0] clr;
        logic level;
        logic rise;
        logic fall;
        logic [PIN_COUNT-1:0] diff_raw;
        logic [PIN_COUNT-1:0] diff_filt;
        logic [PIN_COUNT-1:0] mon;
        logic src_serial1;
        logic src_serial2;
        logic src_chan_d;
        logic [31:0] rd;
        hit = decode(wb_req.adr);
        access = wb_req.cyc && wb_req.stb && !st.ack;
        wr = access && wb_req.we;
        mask = lane_mask(wb_req.sel);
        wbits = wb_req.dat & mask;
        merged = '0;
        chan_sel = '0;
        trig = '0;
        clr = '0;
        level = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        rd = '0;
        next_st = st;

        // pin synchroniser and glitch filter
        next_st.pin_meta = pin_in;
        next_st.pin_sync = st.pin_meta;
        for (int i = 0; i < PIN_COUNT; i++) begin
            next_st.hist[i] = {st.hist[i][FILTER_SAMPLES-2:0], st.pin_sync[i]};
            // level moves only after a full run of equal samples
            if (&st.hist[i]) begin
                next_st.pin_filt[i] = 1'b1;
            end else if (~|st.hist[i]) begin
                next_st.pin_filt[i] = 1'b0;
            end
        end

        // ------------------------------------------------------------
        // trigger detection
        // ------------------------------------------------------------
        chan_sel[0] = SEL_WIDTH'(IRQ_A_PIN);
        chan_sel[1] = SEL_WIDTH'(IRQ_B_PIN);
        chan_sel[2] = st.sel_c;
        chan_sel[3] = st.sel_d;
        for (int c = 0; c < CHAN_COUNT; c++) begin
            level = pick(chan_sel[c], st.cfg_filt[c], st.pin_sync, st.pin_filt);
            rise = level && !st.chan_prev[c];
            fall = !level && st.chan_prev[c];
            next_st.chan_prev[c] = level;
            case (st.cfg_mode[c])
                MODE_RISE: trig[c] = rise;
                MODE_FALL: trig[c] = fall;
                MODE_BOTH: trig[c] = rise || fall;
                MODE_HIGH: trig[c] = level;
                // reserved selector codes never fire a low-level channel
                MODE_LOW: trig[c] = !level && (int'(chan_sel[c]) < PIN_COUNT);
                default: trig[c] = 1'b0;
            endcase
        end
        if (wr && hit.kind == KIND_PEND) begin
            clr = wbits[CHAN_COUNT-1:0];
        end
        // a trigger in the clearing cycle wins
        next_st.pending = (st.pending & ~clr) | trig;

        // ------------------------------------------------------------
        // wake monitor
        // ------------------------------------------------------------
        if (!st.sleeping && sleep_req) begin
            next_st.sleeping = 1'b1;
            next_st.snap_raw = st.pin_sync;
            next_st.snap_filt = st.pin_filt;
        end else if (!sleep_req) begin
            next_st.sleeping = 1'b0;
        end
        diff_raw = st.pin_sync ^ st.snap_raw;
        diff_filt = st.pin_filt ^ st.snap_filt;
        mon = st.wake_en & (st.wake_filt[WF_PINS_BIT] ? diff_filt : diff_raw);
        src_serial1 = serial1_wake_en && (st.wake_filt[WF_SERIAL1_BIT] ?
            diff_filt[SERIAL1_PIN] : diff_raw[SERIAL1_PIN]);
        src_serial2 = serial2_wake_en && (st.wake_filt[WF_SERIAL2_BIT] ?
            diff_filt[SERIAL2_PIN] : diff_raw[SERIAL2_PIN]);
        src_chan_d = chan_d_wake_en &&
            pick(st.sel_d, st.wake_filt[WF_CHAN_D_BIT], diff_raw, diff_filt);
        next_st.wake = st.sleeping && sleep_req &&
            (|mon || src_serial1 || src_serial2 || src_chan_d);

        // ------------------------------------------------------------
        // register writes
        // ------------------------------------------------------------
        if (wr) begin
            case (hit.kind)
                KIND_CFG: begin
                    merged = {23'h00_0000, st.cfg_filt[hit.idx],
                              st.cfg_mode[hit.idx], 5'h00};
                    merged = (merged & ~mask) | wbits;
                    next_st.cfg_filt[hit.idx] = merged[CFG_FILT_BIT];
                    next_st.cfg_mode[hit.idx] = merged[CFG_MODE_LSB +: MODE_WIDTH];
                end
                KIND_OUT: begin
                    if (wb_req.sel[0]) begin
                        next_st.out_data[hit.idx] = wbits[PIN_PER_PORT-1:0];
                    end
                end
                KIND_SET: begin
                    // upper byte is expected zero and is ignored
                    next_st.out_data[hit.idx] =
                        st.out_data[hit.idx] | wbits[PIN_PER_PORT-1:0];
                end
                KIND_CLR: begin
                    next_st.out_data[hit.idx] =
                        st.out_data[hit.idx] & ~wbits[PIN_PER_PORT-1:0];
                end
                KIND_WAKE: begin
                    if (wb_req.sel[0]) begin
                        next_st.wake_en[hit.idx] = wbits[PIN_PER_PORT-1:0];
                    end
                end
                KIND_SEL: begin
                    if (wb_req.sel[0]) begin
                        // reserved codes are stored; they simply route nothing
                        if (hit.idx == 2'h0) begin
                            next_st.sel_c = wbits[SEL_WIDTH-1:0];
                        end else begin
                            next_st.sel_d = wbits[SEL_WIDTH-1:0];
                        end
                    end
                end
                KIND_WFILT: begin
                    if (wb_req.sel[0]) begin
                        next_st.wake_filt = wbits[WAKE_FILT_WIDTH-1:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // ------------------------------------------------------------
        // register reads
        // ------------------------------------------------------------
        case (hit.kind)
            KIND_CFG: begin
                rd[CFG_FILT_BIT] = st.cfg_filt[hit.idx];
                rd[CFG_MODE_LSB +: MODE_WIDTH] = st.cfg_mode[hit.idx];
            end
            KIND_OUT: rd[PIN_PER_PORT-1:0] = st.out_data[hit.idx];
            KIND_WAKE: rd[PIN_PER_PORT-1:0] = st.wake_en[hit.idx];
            KIND_SEL: rd[SEL_WIDTH-1:0] = (hit.idx == 2'h0) ? st.sel_c : st.sel_d;
            KIND_WFILT: rd[WAKE_FILT_WIDTH-1:0] = st.wake_filt;
            KIND_PEND: rd[CHAN_COUNT-1:0] = st.pending;
            default: rd = '0;
        endcase
        // every access is answered, unmapped ones with zero data
        next_st.ack = access;
        next_st.rdata = (access && !wb_req.we) ? rd : '0;
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st <= '0;
            st.sel_c <= SEL_C_RESET;
            st.sel_d <= SEL_D_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign pin_out = st.out_data;
    assign wake_req = st.wake;
    assign irq_pending = st.pending;
    assign wb_rsp.ack = st.ack;
    assign wb_rsp.dat = st.rdata;

endmodule : gpio_wake_irq_block

// ===== gpio_wake_irq_assertions.sv
module gpio_wake_irq_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register bus
    input wire gpio_wake_irq_pkg::wb_req_s wb_req,
    input wire gpio_wake_irq_pkg::wb_rsp_s wb_rsp,
    // pins and status
    input wire logic [gpio_wake_irq_pkg::PIN_COUNT-1:0] pin_out,
    input wire logic sleep_req,
    input wire logic wake_req,
    input wire logic [gpio_wake_irq_pkg::CHAN_COUNT-1:0] irq_pending
);
    import gpio_wake_irq_pkg::*;

    // a request counts only while no ack is showing
    wire logic taken = wb_req.cyc && wb_req.stb && !wb_rsp.ack;
    wire logic wr = taken && wb_req.we;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ----------------------------------------
    // bus, output data, pending and wake
    // ----------------------------------------
    ack_pulse_a: assert property (wb_rsp.ack |=> !wb_rsp.ack)
        else $error("ack longer than one cycle");
    ack_delay_a: assert property (taken |=> wb_rsp.ack)
        else $error("ack not one cycle after request");
    idle_data_a: assert property (!wb_rsp.ack |-> wb_rsp.dat == 32'h0000_0000)
        else $error("read data outside ack");
    set_port_a: assert property (wr && wb_req.adr == ADDR_SET_A && wb_req.sel[0] |=>
        pin_out[7:0] == ($past(pin_out[7:0]) | $past(wb_req.dat[7:0])))
        else $error("output set wrong");
    clr_port_a: assert property (wr && wb_req.adr == ADDR_CLR_B && wb_req.sel[0] |=>
        pin_out[15:8] == ($past(pin_out[15:8]) & ~$past(wb_req.dat[7:0])))
        else $error("output clear wrong");
    out_hold_a: assert property (!wr |=> $stable(pin_out))
        else $error("output data moved without write");
    pend_clear_a: assert property ((($past(irq_pending) & ~irq_pending) != 4'h0) |->
        $past(wr && wb_req.adr == ADDR_PENDING)
        && (($past(irq_pending) & ~irq_pending & ~$past(wb_req.dat[3:0])) == 4'h0))
        else $error("pending dropped without clear");
    wake_drop_a: assert property (!sleep_req |=> !wake_req)
        else $error("wake held after sleep ended");
    wake_cause_a: assert property ($rose(wake_req) |-> $past(sleep_req))
        else $error("wake raised while awake");
endmodule : gpio_wake_irq_assertions

bind gpio_wake_irq_block gpio_wake_irq_assertions chk (.clk(clk), .rst_n(rst_n),
    .wb_req(wb_req), .wb_rsp(wb_rsp), .pin_out(pin_out), .sleep_req(sleep_req),
    .wake_req(wake_req), .irq_pending(irq_pending));

// ===== gpio_pin_model.sv
module gpio_pin_model (
    // clock
    input wire logic clk,
    // levels commanded by the bench
    input wire logic [gpio_wake_irq_pkg::PIN_COUNT-1:0] level,
    // pin side of the block
    output logic [gpio_wake_irq_pkg::PIN_COUNT-1:0] pin_in
);
    import gpio_wake_irq_pkg::*;

    // driven pads move just after an edge, like a real board
    always @(posedge clk) begin
        pin_in <= level;
    end
endmodule : gpio_pin_model

// ===== gpio_set_wake_irq_config_tb.sv
module gpio_set_wake_irq_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import gpio_wake_irq_pkg::*;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    wb_req_s req = '0;
    wb_rsp_s rsp;
    logic [PIN_COUNT-1:0] lvl = '0;
    logic [PIN_COUNT-1:0] pins;
    logic [PIN_COUNT-1:0] pout;
    logic sleep = 1'b0;
    // serial one, serial two, channel d
    logic [2:0] wen = 3'h0;
    logic wake;
    logic [CHAN_COUNT-1:0] pend;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;

    always #2.5 clk = ~clk;

    gpio_wake_irq_block dut (.clk(clk), .rst_n(rst_n), .wb_req(req), .wb_rsp(rsp),
        .pin_in(pins), .pin_out(pout), .sleep_req(sleep), .serial1_wake_en(wen[0]),
        .serial2_wake_en(wen[1]), .chan_d_wake_en(wen[2]), .wake_req(wake),
        .irq_pending(pend));
    gpio_pin_model pads (.clk(clk), .level(lvl), .pin_in(pins));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic conclude();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    // whole run needs about 600 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [31:0] a, d, output logic [31:0] q);
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
        do @(posedge clk); while (rsp.ack !== 1'b1);
        q = rsp.dat;
        req <= '0;
        @(posedge clk);
    endtask : wb

    task automatic wr(input logic [31:0] a, d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr

    task automatic rdc(input logic [31:0] a, exp);
        logic [31:0] q;
        wb(1'b0, a, 32'h0000_0000, q);
        chk(q, exp);
    endtask : rdc

    task automatic pin(input int i, input logic v);
        lvl[i] <= v;
        repeat (10) @(posedge clk);
    endtask : pin

    task automatic pulse(input int i);
        lvl[i] <= 1'b1;
        @(posedge clk);
        pin(i, 1'b0);
    endtask : pulse

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        for (int i = 0; i < 4; i++) rdc(ADDR_CFG_A + 4 * i, 32'h0000_0000);
        for (int i = 0; i < 3; i++) rdc(ADDR_WAKE_A + 4 * i, 32'h0000_0000);
        rdc(ADDR_WAKE_FILT, 32'h0000_0000);
        rdc(ADDR_SEL_C, 32'h0000_000f);
        rdc(ADDR_SEL_D, 32'h0000_0010);
        chk(pend, 4'h0);
    endtask : t_reset

    task automatic t_set();
        logic [31:0] off;
        for (int p = 0; p < 3; p++) begin
            off = 32'h0000_0400 * p;
            wr(ADDR_SET_A + off, 32'h0000_00a5);
            chk(pout[p*8 +: 8], 8'ha5);
            wr(ADDR_SET_A + off, 32'h0000_0042);
            chk(pout[p*8 +: 8], 8'he7);
            rdc(ADDR_OUT_A + off, 32'h0000_00e7);
            rdc(ADDR_SET_A + off, 32'h0000_0000);
            wr(ADDR_CLR_A + off, 32'h0000_0081);
            chk(pout[p*8 +: 8], 8'h66);
        end
        chk(pout, 32'h0066_6666);
    endtask : t_set

    task automatic t_regs();
        wr(ADDR_WAKE_B, 32'h0000_00ff);
        rdc(ADDR_WAKE_B, 32'h0000_00ff);
        wr(ADDR_WAKE_FILT, 32'h0000_000f);
        rdc(ADDR_WAKE_FILT, 32'h0000_000f);
        wr(ADDR_CFG_B, 32'h0000_0180);
        rdc(ADDR_CFG_B, 32'h0000_0180);
        wr(ADDR_SEL_C, 32'h0000_0017);
        rdc(ADDR_SEL_C, 32'h0000_0017);
        rdc(32'h4000_bc20, 32'h0000_0000);
    endtask : t_regs

    task automatic t_modes();
        // expected pending: cleared low, after rise, cleared high, after fall
        logic [3:0] tab [6] = '{4'b0000, 4'b0100, 4'b0001, 4'b0101, 4'b0111, 4'b1101};
        int i;
        for (int c = 2; c < 4; c++) begin
            i = (c == 2) ? 3 : 17;
            wr(ADDR_SEL_C + 4 * (c - 2), (c == 2) ? 32'h0000_0003 : 32'h0000_0011);
            for (int m = 0; m < 6; m++) begin
                wr(ADDR_CFG_A + 4 * c, 32'(m) << 5);
                wr(ADDR_PENDING, 32'h0000_000f);
                chk(pend[c], tab[m][3]);
                pin(i, 1'b1);
                chk(pend[c], tab[m][2]);
                wr(ADDR_PENDING, 32'h0000_000f);
                chk(pend[c], tab[m][1]);
                pin(i, 1'b0);
                chk(pend[c], tab[m][0]);
            end
        end
    endtask : t_modes

    task automatic t_filter();
        wr(ADDR_CFG_C, 32'h0000_0120);
        wr(ADDR_PENDING, 32'h0000_000f);
        pulse(3);
        chk(pend[2], 1'b0);
        pin(3, 1'b1);
        chk(pend[2], 1'b1);
        pin(3, 1'b0);
        wr(ADDR_CFG_C, 32'h0000_0020);
        wr(ADDR_PENDING, 32'h0000_000f);
        pulse(3);
        chk(pend[2], 1'b1);
    endtask : t_filter

    task automatic t_wake();
        wr(ADDR_WAKE_B, 32'h0000_0000);
        wr(ADDR_WAKE_A, 32'h0000_0001);
        wr(ADDR_WAKE_FILT, 32'h0000_0001);
        sleep <= 1'b1;
        repeat (4) @(posedge clk);
        pulse(1);
        chk(wake, 1'b0);
        pulse(0);
        chk(wake, 1'b0);
        pin(0, 1'b1);
        chk(wake, 1'b1);
        sleep <= 1'b0;
        repeat (2) @(posedge clk);
        chk(wake, 1'b0);
        wen <= 3'h1;
        sleep <= 1'b1;
        repeat (4) @(posedge clk);
        pin(10, 1'b1);
        chk(wake, 1'b1);
        sleep <= 1'b0;
        repeat (2) @(posedge clk);
        wen <= 3'h2;
        sleep <= 1'b1;
        repeat (4) @(posedge clk);
        chk(wake, 1'b0);
        pin(2, 1'b1);
        chk(wake, 1'b1);
        sleep <= 1'b0;
        wr(ADDR_WAKE_FILT, 32'h0000_0009);
        wen <= 3'h4;
        sleep <= 1'b1;
        repeat (4) @(posedge clk);
        chk(wake, 1'b0);
        pin(17, 1'b1);
        chk(wake, 1'b1);
        sleep <= 1'b0;
    endtask : t_wake

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_set();
        t_regs();
        t_modes();
        t_filter();
        t_wake();
        conclude();
    end
endmodule : gpio_set_wake_irq_config_tb
